// [hdl/ppfm_port_pin_mux.v]
// port pin function multiplexer: eighteen lines, alternate functions
// ---------------------------------------------------------------
// Notes on behaviour
// RULE1 - third counter match output toggles per underflow, driven on B3
// RULE2 - first counter match output toggles per underflow, on B4
// RULE3 - second counter match output toggles per underflow, on B7
// RULE4 - ir mode drives carrier on A3 through the large-sink driver
// RULE5 - ir mode also drives carrier on B1 with normal sink
// RULE6 - A2 may carry third pwm or third buzzer output
// RULE7 - A2 may be external clock for second and third counters
// RULE8 - A4 may be external clock for 8-bit and first counters
// RULE9 - irq inputs: 0 from A4, 1 from A3, 2 from A5
// RULE10 - A5 never drives high: input or open-drain only
// RULE11 - A5 may serve as active-low external reset input
// RULE12 - A7 may output the instruction clock
// RULE13 - B3 may output first buzzer or comparator result
// RULE14 - B4 may carry first pwm, B6 second pwm
// RULE15 - B2 may output second buzzer
// RULE16 - A6 crystal input, A7 crystal output
// RULE17 - adc inputs 0-4 on A0-A4, 5-11 on B1-B7; A0 high reference
// RULE18 - programming pads: data-in A2, clock A4, data-out A3 or B3
// RULE19 - eighteen lines, each with its own direction control
// RULE20 - pull-down only on A0-A3, A5, B0-B3 and C0-C1
// RULE21 - open-drain mode on every B and C line
// RULE22 - C lines are plain bidirectional, no alternate function
// RULE23 - selected alternate output replaces latch data; deselect restores
// ---------------------------------------------------------------
`timescale 1ns/100ps
`include "ppfm_defs.vh"
module ppfm_port_pin_mux (
  clk,
  rst,
  portAData,
  portBData,
  portCData,
  portADirOut,
  portBDirOut,
  portCDirOut,
  portAPullDownEn,
  portBPullDownEn,
  portCPullDownEn,
  portBOpenDrain,
  portCOpenDrain,
  portA5OpenDrainEn,
  irModeEn,
  irCarrier,
  pwmOutEn,
  pulseWidthOut1,
  pulseWidthOut2,
  pulseWidthOut3,
  buzzerOutEn,
  buzzerOut1,
  buzzerOut2,
  buzzerOut3,
  comparatorOutEn,
  comparatorResultOut,
  timerMatchOutEn,
  counterUnderflow,
  instClockOutEn,
  instClock,
  crystalEn,
  crystalOutDrive,
  extResetEn,
  progModeEn,
  progSerialOut,
  progDataOutOnB3,
  portAIn,
  portBIn,
  portCIn,
  portAOut,
  portAOe,
  portBOut,
  portBOe,
  portCOut,
  portCOe,
  portALargeSink,
  portAPullDown,
  portBPullDown,
  portCPullDown,
  portAReadback,
  portBReadback,
  portCReadback,
  extClockInA,
  extClockInB,
  extIrqInput0,
  extIrqInput1,
  extIrqInput2,
  externalResetN,
  progSerialIn,
  progSerialClk,
  crystalIn,
  timerOneMatchOutput,
  timerTwoMatchOutput,
  timerThreeMatchOutput,
  analogInEnable,
  adcHighReferenceIn
);
  input  wire        clk;
  input  wire        rst;
  input  wire [7:0]  portAData;
  input  wire [7:0]  portBData;
  input  wire [1:0]  portCData;
  input  wire [7:0]  portADirOut;
  input  wire [7:0]  portBDirOut;
  input  wire [1:0]  portCDirOut;
  input  wire [7:0]  portAPullDownEn;
  input  wire [7:0]  portBPullDownEn;
  input  wire [1:0]  portCPullDownEn;
  input  wire [7:0]  portBOpenDrain;
  input  wire [1:0]  portCOpenDrain;
  input  wire        portA5OpenDrainEn;
  input  wire        irModeEn;
  input  wire        irCarrier;
  input  wire [2:0]  pwmOutEn;
  input  wire        pulseWidthOut1;
  input  wire        pulseWidthOut2;
  input  wire        pulseWidthOut3;
  input  wire [2:0]  buzzerOutEn;
  input  wire        buzzerOut1;
  input  wire        buzzerOut2;
  input  wire        buzzerOut3;
  input  wire        comparatorOutEn;
  input  wire        comparatorResultOut;
  input  wire [2:0]  timerMatchOutEn;
  input  wire [2:0]  counterUnderflow;
  input  wire        instClockOutEn;
  input  wire        instClock;
  input  wire        crystalEn;
  input  wire        crystalOutDrive;
  input  wire        extResetEn;
  input  wire        progModeEn;
  input  wire        progSerialOut;
  input  wire        progDataOutOnB3;
  input  wire [7:0]  portAIn;
  input  wire [7:0]  portBIn;
  input  wire [1:0]  portCIn;
  output reg  [7:0]  portAOut;
  output reg  [7:0]  portAOe;
  output reg  [7:0]  portBOut;
  output reg  [7:0]  portBOe;
  output reg  [1:0]  portCOut;
  output reg  [1:0]  portCOe;
  output reg         portALargeSink;
  output reg  [7:0]  portAPullDown;
  output reg  [7:0]  portBPullDown;
  output reg  [1:0]  portCPullDown;
  output reg  [7:0]  portAReadback;
  output reg  [7:0]  portBReadback;
  output reg  [1:0]  portCReadback;
  output reg         extClockInA;
  output reg         extClockInB;
  output reg         extIrqInput0;
  output reg         extIrqInput1;
  output reg         extIrqInput2;
  output reg         externalResetN;
  output reg         progSerialIn;
  output reg         progSerialClk;
  output reg         crystalIn;
  output reg         timerOneMatchOutput;
  output reg         timerTwoMatchOutput;
  output reg         timerThreeMatchOutput;
  output reg  [11:0] analogInEnable;
  output reg         adcHighReferenceIn;

  // ---------------------------------------------------------------
  // pin input synchronisation
  // ---------------------------------------------------------------
  wire [7:0]  aSync;
  wire [7:0]  bSync;
  wire [1:0]  cSync;
  wire [2:0]  matchLevel;

  ppfm_sync3 #(.WIDTH(18)) ppfm_sync3_i (
    .clk     (clk),
    .rst     (rst),
    .asyncIn ({portCIn, portBIn, portAIn}),
    .syncOut ({cSync, bSync, aSync})
  );

  // match toggle on counter underflow
  ppfm_match_toggle #(.N(3)) ppfm_match_toggle_i (
    .clk       (clk),
    .rst       (rst),
    .underflow (counterUnderflow),
    .matchOut  (matchLevel)
  );

  // ---------------------------------------------------------------
  // output data selection
  // ---------------------------------------------------------------
  reg [7:0] aOutD;
  reg [7:0] aOeD;
  reg [7:0] bOutD;
  reg [7:0] bOeD;
  reg [1:0] cOutD;
  reg [1:0] cOeD;

  always @* begin
    // RULE23 latch data default
    aOutD = portAData;
    aOeD  = portADirOut;
    bOutD = portBData;
    bOeD  = portBDirOut;
    // RULE6 pwm before buzzer on A2
    if (pwmOutEn[2]) begin
      aOutD[`PPFM_A_ALT2] = pulseWidthOut3;
      aOeD[`PPFM_A_ALT2]  = 1'b1;
    end else if (buzzerOutEn[2]) begin
      aOutD[`PPFM_A_ALT2] = buzzerOut3;
      aOeD[`PPFM_A_ALT2]  = 1'b1;
    end
    // RULE4 large-sink carrier
    if (irModeEn) begin
      aOutD[`PPFM_A_IRLARGE] = irCarrier;
      aOeD[`PPFM_A_IRLARGE]  = 1'b1;
    end
    // RULE16 crystal pins
    if (crystalEn) begin
      aOutD[`PPFM_A_XOUT] = crystalOutDrive;
      aOeD[`PPFM_A_XOUT]  = 1'b1;
      aOeD[`PPFM_A_XIN]   = 1'b0;
    end else if (instClockOutEn) begin
      // RULE12 instruction clock out
      aOutD[`PPFM_A_XOUT] = instClock;
      aOeD[`PPFM_A_XOUT]  = 1'b1;
    end
    // RULE18 programming data-out pads
    if (progModeEn && !progDataOutOnB3) begin
      aOutD[`PPFM_A_IRLARGE] = progSerialOut;
      aOeD[`PPFM_A_IRLARGE]  = 1'b1;
    end
    // RULE10 open-drain only: drive low, release for high
    aOutD[`PPFM_A_OPENDRN] = 1'b0;
    aOeD[`PPFM_A_OPENDRN]  = portA5OpenDrainEn
                             & portADirOut[`PPFM_A_OPENDRN]
                             & ~portAData[`PPFM_A_OPENDRN] & ~extResetEn;
    // RULE5 normal-sink carrier
    if (irModeEn) begin
      bOutD[`PPFM_B_IRNORM] = irCarrier;
      bOeD[`PPFM_B_IRNORM]  = 1'b1;
    end
    // RULE15 second buzzer
    if (buzzerOutEn[1]) begin
      bOutD[`PPFM_B_BUZ2] = buzzerOut2;
      bOeD[`PPFM_B_BUZ2]  = 1'b1;
    end
    // RULE13 buzzer, comparator; RULE1 match output on B3
    if (progModeEn && progDataOutOnB3) begin
      bOutD[`PPFM_B_ALT3] = progSerialOut;
      bOeD[`PPFM_B_ALT3]  = 1'b1;
    end else if (buzzerOutEn[0]) begin
      bOutD[`PPFM_B_ALT3] = buzzerOut1;
      bOeD[`PPFM_B_ALT3]  = 1'b1;
    end else if (comparatorOutEn) begin
      bOutD[`PPFM_B_ALT3] = comparatorResultOut;
      bOeD[`PPFM_B_ALT3]  = 1'b1;
    end else if (timerMatchOutEn[2]) begin
      bOutD[`PPFM_B_ALT3] = matchLevel[2];
      bOeD[`PPFM_B_ALT3]  = 1'b1;
    end
    // RULE14 first pwm, RULE2 first match on B4
    if (pwmOutEn[0]) begin
      bOutD[`PPFM_B_ALT4] = pulseWidthOut1;
      bOeD[`PPFM_B_ALT4]  = 1'b1;
    end else if (timerMatchOutEn[0]) begin
      bOutD[`PPFM_B_ALT4] = matchLevel[0];
      bOeD[`PPFM_B_ALT4]  = 1'b1;
    end
    // RULE14 second pwm on B6
    if (pwmOutEn[1]) begin
      bOutD[`PPFM_B_PULSE_WIDTH_OUT_2] = pulseWidthOut2;
      bOeD[`PPFM_B_PULSE_WIDTH_OUT_2]  = 1'b1;
    end
    // RULE3 second match on B7
    if (timerMatchOutEn[1]) begin
      bOutD[`PPFM_B_TMR2] = matchLevel[1];
      bOeD[`PPFM_B_TMR2]  = 1'b1;
    end
    // RULE21 open-drain: only low is driven
    bOeD  = bOeD & ~(portBOpenDrain & bOutD);
    // RULE22 port C plain, RULE21 open-drain
    cOutD = portCData;
    cOeD  = portCDirOut & ~(portCOpenDrain & portCData);
  end

  // ---------------------------------------------------------------
  // registered outputs
  // ---------------------------------------------------------------
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      {portAOut, portAOe, portBOut, portBOe, portCOut, portCOe} <= 36'h0;
      {portALargeSink, portAPullDown, portBPullDown, portCPullDown} <= 19'h0;
      {portAReadback, portBReadback, portCReadback} <= 18'h0;
      {extClockInA, extClockInB} <= 2'h0;
      {extIrqInput0, extIrqInput1, extIrqInput2} <= 3'h0;
      externalResetN        <= 1'b1;
      {progSerialIn, progSerialClk, crystalIn} <= 3'h0;
      {timerOneMatchOutput, timerTwoMatchOutput, timerThreeMatchOutput} <= 3'h0;
      {analogInEnable, adcHighReferenceIn} <= 13'h0;
    end else begin
      // RULE19 per-line direction result
      portAOut <= aOutD;
      portAOe  <= aOeD;
      portBOut <= bOutD;
      portBOe  <= bOeD;
      portCOut <= cOutD;
      portCOe  <= cOeD;
      portALargeSink <= irModeEn;
      // RULE20 pull-down only on capable input lines
      portAPullDown <= portAPullDownEn & ~aOeD & `PPFM_PD_MASK_A;
      portBPullDown <= portBPullDownEn & ~bOeD & `PPFM_PD_MASK_B;
      portCPullDown <= portCPullDownEn & ~cOeD & `PPFM_PD_MASK_C;
      portAReadback <= aSync;
      portBReadback <= bSync;
      portCReadback <= cSync;
      // RULE8 clock a from A4, RULE7 clock b from A2
      extClockInA <= aSync[`PPFM_A_CLKA];
      extClockInB <= aSync[`PPFM_A_ALT2];
      // RULE9 irq routing
      extIrqInput0 <= aSync[`PPFM_A_CLKA];
      extIrqInput1 <= aSync[`PPFM_A_IRLARGE];
      extIrqInput2 <= aSync[`PPFM_A_OPENDRN];
      // RULE11 reset pin, held inactive when not selected
      externalResetN <= extResetEn ? aSync[`PPFM_A_OPENDRN] : 1'b1;
      // RULE18 programming inputs
      progSerialIn  <= progModeEn & aSync[`PPFM_A_ALT2];
      progSerialClk <= progModeEn & aSync[`PPFM_A_CLKA];
      crystalIn     <= crystalEn & aSync[`PPFM_A_XIN];
      timerOneMatchOutput   <= matchLevel[0];
      timerTwoMatchOutput   <= matchLevel[1];
      timerThreeMatchOutput <= matchLevel[2];
      // RULE17 analog channel enables follow input lines
      analogInEnable <= {~bOeD[7:1], ~aOeD[4:0]};
      adcHighReferenceIn <= aSync[`PPFM_A_ADCREF];
    end
  end
endmodule

// [hdl/ppfm_defs.vh]
// constants for the port pin function multiplexer
`ifndef PPFM_DEFS_VH
`define PPFM_DEFS_VH
// ---------------------------------------------------------------
// line positions
// ---------------------------------------------------------------
`define PPFM_A_ADCREF   0
`define PPFM_A_ALT2     2
`define PPFM_A_IRLARGE  3
`define PPFM_A_CLKA     4
`define PPFM_A_OPENDRN  5
`define PPFM_A_XIN      6
`define PPFM_A_XOUT     7
`define PPFM_B_IRNORM   1
`define PPFM_B_BUZ2     2
`define PPFM_B_ALT3     3
`define PPFM_B_ALT4     4
`define PPFM_B_PULSE_WIDTH_OUT_2     6
`define PPFM_B_TMR2     7
// ---------------------------------------------------------------
// pull-down capability masks
// ---------------------------------------------------------------
`define PPFM_PD_MASK_A  8'h2f
`define PPFM_PD_MASK_B  8'h0f
`define PPFM_PD_MASK_C  2'h3
// ---------------------------------------------------------------
// alternate output selector codes
// ---------------------------------------------------------------
`define PPFM_SEL_PORT   2'h0
`define PPFM_SEL_ALT1   2'h1
`define PPFM_SEL_ALT2   2'h2
`define PPFM_SEL_ALT3   2'h3
`define PPFM_RST_LOW    1'h0
`endif

// [hdl/ppfm_sync3.v]
// three-stage input synchroniser with agreement filter
`timescale 1ns/100ps
module ppfm_sync3 #(
  parameter WIDTH = 8
) (
  clk,
  rst,
  asyncIn,
  syncOut
);
  input  wire             clk;
  input  wire             rst;
  input  wire [WIDTH-1:0] asyncIn;
  output reg  [WIDTH-1:0] syncOut;

  reg [WIDTH-1:0] st1_q;
  reg [WIDTH-1:0] st2_q;
  reg [WIDTH-1:0] st3_q;
  integer i;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      st1_q   <= {WIDTH{1'b0}};
      st2_q   <= {WIDTH{1'b0}};
      st3_q   <= {WIDTH{1'b0}};
      syncOut <= {WIDTH{1'b0}};
    end else begin
      st1_q <= asyncIn;
      st2_q <= st1_q;
      st3_q <= st2_q;
      // a change counts only when stages two and three agree
      for (i = 0; i < WIDTH; i = i + 1) begin
        if (st2_q[i] == st3_q[i]) begin
          syncOut[i] <= st3_q[i];
        end
      end
    end
  end
endmodule

// [hdl/ppfm_match_toggle.v]
// underflow-driven toggle outputs for the three down counters
`timescale 1ns/100ps
module ppfm_match_toggle #(
  parameter N = 3
) (
  clk,
  rst,
  underflow,
  matchOut
);
  input  wire         clk;
  input  wire         rst;
  input  wire [N-1:0] underflow;
  output reg  [N-1:0] matchOut;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      matchOut <= {N{1'b0}};
    end else begin
      // one level flip per underflow pulse
      matchOut <= matchOut ^ underflow;
    end
  end
endmodule

// [sim/ppfm_board_model.sv]
// board circuitry model seen by the eighteen port pins
`timescale 1ns/100ps
module ppfm_board_model (
  input  logic        clk,
  input  logic [17:0] padOut,
  input  logic [17:0] padOe,
  input  logic [17:0] pullDown,
  input  logic [17:0] extLevel,
  input  logic [17:0] extEn,
  output logic [17:0] pinLevel
);
  logic [17:0] last_q = '0;

  // unpulled floating lines wander so stale levels never read back
  always @(posedge clk) begin
    last_q <= pinLevel;
  end
  assign pinLevel = (padOe & padOut) | (~padOe & extEn & extLevel) |
                    (~padOe & ~extEn & ~pullDown & ~last_q);
endmodule

// [sim/ppfm_port_pin_mux_assertions.sv]
// concurrent checks on the pin mux top-level ports
`timescale 1ns/100ps
module ppfm_mux_checker (
  input logic       clk,
  input logic       rst,
  input logic [7:0] portAOut,
  input logic [7:0] portAOe,
  input logic [7:0] portAIn,
  input logic [7:0] portADirOut,
  input logic [7:0] portAPullDownEn,
  input logic [7:0] portAPullDown,
  input logic       portALargeSink,
  input logic       irModeEn,
  input logic [2:0] counterUnderflow,
  input logic       timerOneMatchOutput,
  input logic       timerThreeMatchOutput,
  input logic       extIrqInput1,
  input logic       extIrqInput2,
  input logic       extResetEn,
  input logic       externalResetN
);
  logic [2:0] upCnt_q;
  logic       settled;

  // $past reaches two edges back, so wait four edges after reset
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      upCnt_q <= 3'h0;
    end else if (upCnt_q != 3'h4) begin
      upCnt_q <= upCnt_q + 3'h1;
    end
  end
  assign settled = (upCnt_q == 3'h4);

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a5_no_high_a: assert property (
    portAOe[5] |-> !portAOut[5]) else $error("A5 driven high");
  ir_large_a: assert property (
    settled |-> portALargeSink == $past(irModeEn))
    else $error("large sink does not follow ir mode");
  match_one_a: assert property (
    settled |-> $changed(timerOneMatchOutput) ==
    $past(counterUnderflow[0], 2)) else $error("match one toggle wrong");
  match_three_a: assert property (
    settled |-> $changed(timerThreeMatchOutput) ==
    $past(counterUnderflow[2], 2)) else $error("match three toggle wrong");
  irq_one_a: assert property (
    $stable(portAIn[3]) [*6] |-> extIrqInput1 == portAIn[3])
    else $error("irq one not from A3");
  irq_two_a: assert property (
    $stable(portAIn[5]) [*6] |-> extIrqInput2 == portAIn[5])
    else $error("irq two not from A5");
  pull_down_a: assert property (
    settled |-> portAPullDown == ($past(portAPullDownEn) &
    ~$past(portADirOut) & 8'h2f)) else $error("pull-down A wrong");
  reset_idle_a: assert property (
    !extResetEn [*6] |-> externalResetN)
    else $error("reset input active while unused");
endmodule

bind ppfm_port_pin_mux ppfm_mux_checker ppfm_mux_checker_i (.*);

// [sim/test_port_pin_function_mux.sv]
// self-checking bench for the port pin function multiplexer
`timescale 1ns/100ps
module test_port_pin_function_mux;
  logic        clk = '0, rst = '1, portA5OpenDrainEn = '0, irModeEn = '0;
  logic        irCarrier = '0, pulseWidthOut1 = '0, pulseWidthOut2 = '0;
  logic        pulseWidthOut3 = '0, buzzerOut1 = '0, buzzerOut2 = '0;
  logic        buzzerOut3 = '0, comparatorOutEn = '0, instClock = '0;
  logic        comparatorResultOut = '0, instClockOutEn = '0;
  logic        crystalEn = '0, crystalOutDrive = '0, extResetEn = '0;
  logic        progModeEn = '0, progSerialOut = '0, progDataOutOnB3 = '0;
  logic [7:0]  portAData = '0, portBData = '0, portADirOut = '0;
  logic [7:0]  portBDirOut = '0, portAPullDownEn = '0, portBOpenDrain = '0;
  logic [7:0]  portBPullDownEn = '0;
  logic [1:0]  portCData = '0, portCDirOut = '0, portCOpenDrain = '0;
  logic [1:0]  portCPullDownEn = '0;
  logic [2:0]  pwmOutEn = '0, buzzerOutEn = '0, timerMatchOutEn = '0;
  logic [2:0]  counterUnderflow = '0;
  logic [17:0] extLevel = '0, extEn = '0;
  wire  [7:0]  portAIn, portBIn;
  wire  [1:0]  portCIn;
  logic [7:0]  portAOut, portAOe, portBOut, portBOe, portAPullDown;
  logic [7:0]  portBPullDown, portAReadback, portBReadback;
  logic [1:0]  portCOut, portCOe, portCPullDown, portCReadback;
  logic        portALargeSink, extClockInA, extClockInB, extIrqInput0;
  logic        extIrqInput1, extIrqInput2, externalResetN, progSerialIn;
  logic        progSerialClk, crystalIn, timerOneMatchOutput;
  logic        timerTwoMatchOutput, timerThreeMatchOutput;
  logic        adcHighReferenceIn;
  logic [11:0] analogInEnable;
  int          miscompares = 0;
  int          check_count = 0;
  int          k;
  logic [15:0] expAlt [9] = '{16'h1000, 16'h4000, 16'h0004, 16'h0800,
                              16'h0400, 16'h0004, 16'h0800, 16'h0080,
                              16'h0208};
  logic [8:0]  expIn [5] = '{9'h084, 9'h020, 9'h142, 9'h018, 9'h001};
  logic [2:0]  expMatch [4] = '{3'h1, 3'h3, 3'h7, 3'h0};
  wire  [15:0] padsBA = {portBOut, portAOut};
  wire  [2:0]  matchBits = {timerThreeMatchOutput, timerTwoMatchOutput,
                            timerOneMatchOutput};
  wire  [2:0]  matchPads = {portBOut[3], portBOut[7], portBOut[4]};
  wire  [8:0]  inBits = {extClockInA, extClockInB, extIrqInput0,
                         extIrqInput1, extIrqInput2, externalResetN,
                         progSerialIn, progSerialClk, crystalIn};
  wire  [16:0] readBits = {portCReadback, portBReadback, portAReadback[6:0]};

  ppfm_port_pin_mux ppfm_port_pin_mux_i (.*);
  ppfm_board_model ppfm_board_model_i (
    .clk      (clk),
    .padOut   ({portCOut, portBOut, portAOut}),
    .padOe    ({portCOe, portBOe, portAOe}),
    .pullDown ({portCPullDown, portBPullDown, portAPullDown}),
    .extLevel (extLevel),
    .extEn    (extEn),
    .pinLevel ({portCIn, portBIn, portAIn})
  );

  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    check_count++;
    if (seen !== want) begin
      miscompares++;
      $display("BAD %0t seen %h want %h", $time, seen, want);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic tally_and_finish;
    if (miscompares == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic setAlt(input int n, input logic v);
    case (n)
      0: pwmOutEn[0] = v;
      1: pwmOutEn[1] = v;
      2: pwmOutEn[2] = v;
      3: buzzerOutEn[0] = v;
      4: buzzerOutEn[1] = v;
      5: buzzerOutEn[2] = v;
      6: comparatorOutEn = v;
      7: instClockOutEn = v;
      default: irModeEn = v;
    endcase
  endtask

  initial begin
    forever #5 clk = ~clk;
  end
  // far beyond the 97 cycles the sequence needs
  initial begin
    #20000;
    miscompares++;
    tally_and_finish;
  end
  initial begin
    tick(5);
    check({externalResetN, portAOe, portBOe}, 17'h10000);
    rst = 1'b0;
    {portADirOut, portBDirOut, portCDirOut} = 18'h3ffff;
    portCData = 2'h1;
    {pulseWidthOut1, pulseWidthOut2, pulseWidthOut3} = 3'h7;
    {buzzerOut1, buzzerOut2, buzzerOut3, comparatorResultOut} = 4'hf;
    {instClock, irCarrier} = 2'h3;
    for (k = 0; k < 9; k++) begin
      setAlt(k, 1'b1);
      tick(2);
      check(padsBA, expAlt[k]);
      check(portCOut, 2'h1);
      setAlt(k, 1'b0);
      tick(2);
      check(padsBA, 16'h0000);
    end
    timerMatchOutEn = 3'h7;
    for (k = 0; k < 4; k++) begin
      counterUnderflow = (k == 3) ? 3'h7 : 3'h1 << k;
      tick(1);
      counterUnderflow = 3'h0;
      tick(3);
      check(matchBits, expMatch[k]);
      check(matchPads, expMatch[k]);
    end
    timerMatchOutEn = 3'h0;
    {portBOpenDrain, portCOpenDrain, portA5OpenDrainEn} = 11'h7ff;
    {portAData, portBData, portCData} = 18'h3ffff;
    tick(2);
    check({portCOe, portBOe, portAOe[5]}, 11'h000);
    {portAData, portBData, portCData} = 18'h0;
    tick(2);
    check({portCOe, portBOe, portAOe[5], portAOut[5]}, 12'hffe);
    {portBOpenDrain, portCOpenDrain, portA5OpenDrainEn} = 11'h0;
    {portADirOut, portBDirOut, portCDirOut} = 18'h0;
    // data-out on B3 keeps A3 free as an input
    {crystalEn, progModeEn, extResetEn, progDataOutOnB3} = 4'hf;
    extEn = 18'h3ffff;
    for (k = 0; k < 5; k++) begin
      extLevel = {10'h2a5, (8'h1 << (k + 2)) | {7'h0, k[0]}};
      tick(6);
      check(inBits, expIn[k]);
      check(readBits, {extLevel[17:8], extLevel[6:0]});
      check(adcHighReferenceIn, extLevel[0]);
    end
    extEn = 18'h0;
    {portADirOut, portBDirOut} = 16'h15aa;
    {portAPullDownEn, portBPullDownEn, portCPullDownEn} = 18'h3ffff;
    tick(6);
    check({portCPullDown, portBPullDown, portAPullDown}, 18'h3052a);
    check(analogInEnable, 12'h54a);
    tally_and_finish;
  end
endmodule
